// ### bench/sdram_bank_command_rules_test.sv
// Self-checking bench of the bank command tracker
module sdram_bank_command_rules_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic srst;
  sdram_pkg::pins_t pins;
  logic clock_gate;
  sdram_pkg::cmd_t cmd_q;
  logic cmd_accepted_q;
  logic cmd_illegal_q;
  sdram_pkg::bank_state_t [sdram_pkg::NUM_BANKS-1:0] bs;
  sdram_pkg::dev_state_t ds;
  logic all_idle;
  logic read_start;
  logic [1:0] read_bank;
  logic wr_accept;
  logic [1:0] wr_bank;
  int err_count;
  int cmp_count;

  sdram_ctrl_model i_sdram_ctrl_model (.clock(clock), .pins(pins), .clock_gate(clock_gate));
  sdram_bank_command_rules i_sdram_bank_command_rules (.clock(clock), .srst(srst),
    .pins(pins), .clock_gate(clock_gate), .cmd_q(cmd_q), .cmd_accepted_q(cmd_accepted_q),
    .cmd_illegal_q(cmd_illegal_q), .bank_state(bs), .dev_state_q(ds), .all_idle(all_idle),
    .read_bus_start_q(read_start), .read_bus_bank_q(read_bank), .write_accept_q(wr_accept),
    .write_accept_bank_q(wr_bank));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Pins need two sync edges before they are applied
  task automatic send(input logic [2:0] p, input logic [1:0] b, input logic ap, input logic a);
    i_sdram_ctrl_model.issue(p, b, ap);
    wait_cyc(2);
    chk(cmd_accepted_q === a, "accept flag");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk(bs === {4{sdram_pkg::BANK_IDLE}} && ds === sdram_pkg::DEV_NORMAL, "reset");
  endtask
  task automatic t_cross();
    send(sdram_pkg::PAT_ACTIVE, 2'h0, 1'b0, 1'b1);
    chk(bs[0] === sdram_pkg::BANK_ACTIVATING, "activating");
    send(sdram_pkg::PAT_ACTIVE, 2'h1, 1'b0, 1'b1);
    chk(bs[0] === sdram_pkg::BANK_ACTIVE, "row active");
    send(sdram_pkg::PAT_READ, 2'h0, 1'b0, 1'b1);
    chk(bs[0] === sdram_pkg::BANK_READING, "reading");
    send(sdram_pkg::PAT_WRITE, 2'h1, 1'b0, 1'b1);
    chk(bs[0] === sdram_pkg::BANK_ACTIVE && bs[1] === sdram_pkg::BANK_WRITING, "cut");
    send(sdram_pkg::PAT_TERMINATE, 2'h1, 1'b0, 1'b1);
    chk(bs[1] === sdram_pkg::BANK_ACTIVE, "terminate");
  endtask
  task automatic t_auto();
    send(sdram_pkg::PAT_READ, 2'h0, 1'b1, 1'b1);
    chk(bs[0] === sdram_pkg::BANK_READ_AP, "read ap");
    send(sdram_pkg::PAT_NOP, 2'h0, 1'b0, 1'b0);
    chk(bs[0] === sdram_pkg::BANK_READ_AP, "nop kept");
    wait_cyc(3);
    chk(bs[0] === sdram_pkg::BANK_IDLE, "read ap end");
    send(sdram_pkg::PAT_WRITE, 2'h1, 1'b1, 1'b1);
    chk(bs[1] === sdram_pkg::BANK_WRITE_AP, "write ap");
    wait_cyc(6);
    chk(bs[1] === sdram_pkg::BANK_IDLE, "write ap end");
  endtask
  task automatic t_global();
    send(sdram_pkg::PAT_PRECHARGE, 2'h1, 1'b0, 1'b1);
    chk(bs[1] === sdram_pkg::BANK_IDLE, "idle precharge");
    send(sdram_pkg::PAT_REFRESH, 2'h0, 1'b0, 1'b1);
    chk(ds === sdram_pkg::DEV_REFRESHING, "refreshing");
    send(sdram_pkg::PAT_ACTIVE, 2'h0, 1'b0, 1'b0);
    chk(cmd_illegal_q === 1'b1 && bs[0] === sdram_pkg::BANK_IDLE, "busy refuse");
    wait_cyc(5);
    chk(ds === sdram_pkg::DEV_NORMAL && all_idle === 1'b1, "refresh end");
    send(sdram_pkg::PAT_MODE_LOAD, 2'h0, 1'b0, 1'b1);
    chk(ds === sdram_pkg::DEV_MODE_ACCESS, "mode access");
    wait_cyc(2);
    chk(ds === sdram_pkg::DEV_NORMAL, "mode end");
    send(sdram_pkg::PAT_ACTIVE, 2'h3, 1'b0, 1'b1);
    send(sdram_pkg::PAT_PRECHARGE, 2'h0, 1'b1, 1'b1);
    chk(ds === sdram_pkg::DEV_PRECHARGE_ALL, "pall");
    chk(bs[3] === sdram_pkg::BANK_PRECHARGING, "pall bank");
    wait_cyc(2);
    chk(ds === sdram_pkg::DEV_NORMAL && all_idle === 1'b1, "pall end");
  endtask
  // Gate and pins fall together, so the synced gate is low with its previous value high
  task automatic t_sleep();
    i_sdram_ctrl_model.set_gate(1'b0);
    send(sdram_pkg::PAT_TERMINATE, 2'h0, 1'b0, 1'b1);
    chk(ds === sdram_pkg::DEV_DEEP_SLEEP, "deep sleep");
    send(sdram_pkg::PAT_ACTIVE, 2'h0, 1'b0, 1'b0);
    chk(cmd_illegal_q === 1'b1 && bs[0] === sdram_pkg::BANK_IDLE, "gate low refuse");
    i_sdram_ctrl_model.set_gate(1'b1);
    wait_cyc(3);
    chk(ds === sdram_pkg::DEV_NORMAL, "sleep exit");
  endtask
  task automatic t_bus();
    send(sdram_pkg::PAT_ACTIVE, 2'h2, 1'b0, 1'b1);
    send(sdram_pkg::PAT_ACTIVE, 2'h3, 1'b0, 1'b1);
    send(sdram_pkg::PAT_WRITE, 2'h2, 1'b0, 1'b1);
    chk(wr_accept === 1'b1 && wr_bank === 2'h2, "first write word");
    send(sdram_pkg::PAT_READ, 2'h3, 1'b0, 1'b1);
    chk(wr_accept === 1'b0 && bs[2] === sdram_pkg::BANK_ACTIVE, "write cut by read");
    wait_cyc(2);
    chk(read_start === 1'b1 && read_bank === 2'h3, "read bus owner");
  endtask

  initial begin
    srst = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    wait_cyc(2);
    t_reset();
    t_cross();
    t_auto();
    t_global();
    t_sleep();
    t_bus();
    finish_test();
  end
  // Whole run needs about 100 cycles
  initial begin
    repeat (1000) @(posedge clock);
    err_count++;
    finish_test();
  end
endmodule

// ### bench/sdram_ctrl_model.sv
// Memory controller model driving the command pins
module sdram_ctrl_model (
  // Clock
  input wire logic clock,
  // Command pins
  output sdram_pkg::pins_t pins,
  output logic clock_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // gate high unless a scenario lowers it
  initial clock_gate = 1'b1;
  initial pins = 7'h7f;
  task automatic issue(input logic [2:0] pat, input logic [1:0] bk, input logic ap);
    pins = {1'b0, pat, bk, ap};
    @(posedge clock);
    // Released lines flip so stale values never look valid
    #1 pins = {1'b1, ~pat, ~bk, ~ap};
  endtask
  // clock gate level, seen by the tracker through two sync flops
  task automatic set_gate(input logic g);
    clock_gate = g;
  endtask
endmodule

// ### bench/sdram_rules_props.sv
// Checker of bank and device state rules
module sdram_rules_props #(
  parameter int BURST_LEN = 4,
  parameter int READ_LATENCY = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Observed outputs
  input wire sdram_pkg::cmd_t cmd_q,
  input wire logic cmd_accepted_q,
  input wire logic cmd_illegal_q,
  input wire sdram_pkg::bank_state_t [sdram_pkg::NUM_BANKS-1:0] bank_state,
  input wire sdram_pkg::dev_state_t dev_state_q,
  input wire logic all_idle,
  input wire logic read_bus_start_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edge of the pulse is not pinned down, so one cycle of slack
  localparam int RL_LO = READ_LATENCY - 1;
  localparam int RL_HI = READ_LATENCY;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ----
  // Assertions
  // ----
  one_verdict_a: assert property (
    !(cmd_accepted_q && cmd_illegal_q)) else $error("accepted and refused");
  quiet_nop_a: assert property (
    cmd_q.code inside {sdram_pkg::CMD_INHIBIT, sdram_pkg::CMD_NOP}
    |-> !cmd_accepted_q && !cmd_illegal_q) else $error("nop not quiet");
  busy_refuse_a: assert property (
    cmd_accepted_q |-> $past(dev_state_q) == sdram_pkg::DEV_NORMAL)
    else $error("command taken while busy");
  refresh_len_a: assert property (
    $rose(dev_state_q == sdram_pkg::DEV_REFRESHING)
    |-> (dev_state_q == sdram_pkg::DEV_REFRESHING)[*8] ##1 all_idle)
    else $error("refresh length wrong");
  mode_len_a: assert property (
    $rose(dev_state_q == sdram_pkg::DEV_MODE_ACCESS) |-> ##2
    dev_state_q == sdram_pkg::DEV_NORMAL && all_idle) else $error("mode access length");
  pall_len_a: assert property (
    $rose(dev_state_q == sdram_pkg::DEV_PRECHARGE_ALL)
    |-> (dev_state_q == sdram_pkg::DEV_PRECHARGE_ALL)[*2] ##1 all_idle)
    else $error("precharge all length");
  rdap_end_a: assert property (
    $rose(bank_state[0] == sdram_pkg::BANK_READ_AP)
    |-> ##[1:6] bank_state[0] == sdram_pkg::BANK_IDLE) else $error("read ap stuck");
  act_open_a: assert property (
    cmd_accepted_q && cmd_q.code == sdram_pkg::CMD_ACTIVE && cmd_q.bank == 2'h0
    |-> bank_state[0] == sdram_pkg::BANK_ACTIVATING ##2
    bank_state[0] == sdram_pkg::BANK_ACTIVE) else $error("activate timing");
  idle_pre_a: assert property (
    cmd_accepted_q && cmd_q.code == sdram_pkg::CMD_PRECHARGE && cmd_q.bank == 2'h1
    && !cmd_q.auto_precharge && $past(bank_state[1]) == sdram_pkg::BANK_IDLE
    |-> bank_state[1] == sdram_pkg::BANK_IDLE) else $error("idle precharge moved");
  read_bus_a: assert property (
    cmd_accepted_q && cmd_q.code == sdram_pkg::CMD_READ |-> ##[RL_LO:RL_HI]
    read_bus_start_q) else $error("read bus late");
  cover property (dev_state_q == sdram_pkg::DEV_REFRESHING);
  cover property (cmd_illegal_q);
  cover property (bank_state[0] == sdram_pkg::BANK_READ_AP);
endmodule
bind sdram_bank_command_rules sdram_rules_props #(.BURST_LEN(BURST_LEN),
  .READ_LATENCY(READ_LATENCY)) i_sdram_rules_props (.clock(clock), .srst(srst),
  .cmd_q(cmd_q), .cmd_accepted_q(cmd_accepted_q), .cmd_illegal_q(cmd_illegal_q),
  .bank_state(bank_state), .dev_state_q(dev_state_q), .all_idle(all_idle),
  .read_bus_start_q(read_bus_start_q));

// ### hw/bank_tracker.sv
// State machine and timers of one bank
module bank_tracker #(
  parameter int BURST_LEN = sdram_pkg::BURST_LEN_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Accepted command and its relation to this bank
  input sdram_pkg::cmd_t cmd,
  input wire logic hit,
  input wire logic other_burst,
  input wire logic terminate,
  // State
  output sdram_pkg::bank_state_t state_q,
  output logic write_beat
);

  localparam logic [sdram_pkg::CNT_W-1:0] BURST_LOAD = sdram_pkg::CNT_W'(BURST_LEN - 1);

  logic [sdram_pkg::CNT_W-1:0] cnt_q;
  logic pre_phase_q;
  logic rw_go;
  logic pre_go;
  logic cnt_done;
  sdram_pkg::bank_state_t rw_state;

  assign cnt_done = (cnt_q == sdram_pkg::CNT_ZERO);
  assign rw_go = hit && (cmd.code == sdram_pkg::CMD_READ || cmd.code == sdram_pkg::CMD_WRITE);
  assign pre_go = (cmd.code == sdram_pkg::CMD_PRECHARGE) && (hit || cmd.auto_precharge);
  assign rw_state = (cmd.code == sdram_pkg::CMD_READ) ?
      (cmd.auto_precharge ? sdram_pkg::BANK_READ_AP : sdram_pkg::BANK_READING) :
      (cmd.auto_precharge ? sdram_pkg::BANK_WRITE_AP : sdram_pkg::BANK_WRITING);
  // Beats after the registering edge; that edge itself is counted upstream
  assign write_beat = !cnt_done && (state_q == sdram_pkg::BANK_WRITING ||
      (state_q == sdram_pkg::BANK_WRITE_AP && !pre_phase_q));

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= sdram_pkg::BANK_IDLE;
      cnt_q <= sdram_pkg::CNT_ZERO;
      pre_phase_q <= 1'b0;
    end else begin
      case (state_q)
        sdram_pkg::BANK_IDLE: begin
          if (hit && cmd.code == sdram_pkg::CMD_ACTIVE) begin
            state_q <= sdram_pkg::BANK_ACTIVATING;
            cnt_q <= sdram_pkg::ACTIVATE_LOAD;
          end
        end
        sdram_pkg::BANK_ACTIVATING: begin
          if (cnt_done) begin
            state_q <= sdram_pkg::BANK_ACTIVE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        sdram_pkg::BANK_ACTIVE, sdram_pkg::BANK_READING, sdram_pkg::BANK_WRITING: begin
          if (rw_go) begin
            state_q <= rw_state;
            cnt_q <= BURST_LOAD;
            pre_phase_q <= 1'b0;
          end else if (pre_go) begin
            state_q <= sdram_pkg::BANK_PRECHARGING;
            cnt_q <= sdram_pkg::PRECHARGE_LOAD;
          end else if (state_q != sdram_pkg::BANK_ACTIVE) begin
            if (other_burst || terminate || cnt_done) begin
              state_q <= sdram_pkg::BANK_ACTIVE;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
        sdram_pkg::BANK_READ_AP, sdram_pkg::BANK_WRITE_AP: begin
          if (!pre_phase_q && (other_burst || cnt_done)) begin
            pre_phase_q <= 1'b1;
            cnt_q <= sdram_pkg::PRECHARGE_LOAD;
          end else if (pre_phase_q && cnt_done) begin
            state_q <= sdram_pkg::BANK_IDLE;
            pre_phase_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        sdram_pkg::BANK_PRECHARGING: begin
          if (cnt_done) begin
            state_q <= sdram_pkg::BANK_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= sdram_pkg::BANK_IDLE;
          cnt_q <= sdram_pkg::CNT_ZERO;
          pre_phase_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### hw/sdram_bank_command_rules.sv
// Command decoder, device state and four bank trackers
module sdram_bank_command_rules #(
  parameter int BURST_LEN = sdram_pkg::BURST_LEN_DEF,
  parameter int READ_LATENCY = sdram_pkg::READ_LATENCY_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Command pins from the controller
  input sdram_pkg::pins_t pins,
  input wire logic clock_gate,
  // Decoded command
  output sdram_pkg::cmd_t cmd_q,
  output logic cmd_accepted_q,
  output logic cmd_illegal_q,
  // Bank and device state
  output sdram_pkg::bank_state_t [sdram_pkg::NUM_BANKS-1:0] bank_state,
  output sdram_pkg::dev_state_t dev_state_q,
  output logic all_idle,
  // Data bus ownership
  output logic read_bus_start_q,
  output logic [1:0] read_bus_bank_q,
  output logic write_accept_q,
  output logic [1:0] write_accept_bank_q
);

  localparam int NB = sdram_pkg::NUM_BANKS;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  sdram_pkg::pins_t pins_meta_q;
  sdram_pkg::pins_t pins_q;
  logic gate_meta_q;
  logic gate_q;
  logic gate_prev_q;

  // Commands lag the pins by two cycles; timing is counted from here
  always_ff @(posedge clock) begin
    if (srst) begin
      pins_meta_q <= '1;
      pins_q <= '1;
    end else begin
      pins_meta_q <= pins;
      pins_q <= pins_meta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gate_meta_q <= 1'b1;
      gate_q <= 1'b1;
      gate_prev_q <= 1'b1;
    end else begin
      gate_meta_q <= clock_gate;
      gate_q <= gate_meta_q;
      gate_prev_q <= gate_q;
    end
  end

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  sdram_pkg::cmd_t dec;
  logic [2:0] pat;

  assign pat = {pins_q.row_strobe_n, pins_q.column_strobe_n, pins_q.write_strobe_n};

  always_comb begin
    dec.bank = pins_q.bank;
    dec.auto_precharge = pins_q.auto_precharge;
    dec.code = sdram_pkg::CMD_NOP;
    if (pins_q.chip_select_n) begin
      dec.code = sdram_pkg::CMD_INHIBIT;
    end else begin
      case (pat)
        sdram_pkg::PAT_NOP: dec.code = sdram_pkg::CMD_NOP;
        sdram_pkg::PAT_ACTIVE: dec.code = sdram_pkg::CMD_ACTIVE;
        sdram_pkg::PAT_READ: dec.code = sdram_pkg::CMD_READ;
        sdram_pkg::PAT_WRITE: dec.code = sdram_pkg::CMD_WRITE;
        sdram_pkg::PAT_PRECHARGE: dec.code = sdram_pkg::CMD_PRECHARGE;
        sdram_pkg::PAT_REFRESH:
          dec.code = gate_q ? sdram_pkg::CMD_REFRESH : sdram_pkg::CMD_SELF_REFRESH;
        sdram_pkg::PAT_MODE_LOAD: dec.code = sdram_pkg::CMD_MODE_LOAD;
        sdram_pkg::PAT_TERMINATE:
          dec.code = gate_q ? sdram_pkg::CMD_TERMINATE : sdram_pkg::CMD_DEEP_SLEEP;
        default: dec.code = sdram_pkg::CMD_NOP;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Legality against the addressed bank, all banks or the last burst bank
  // --------------------------------------------------------------------------
  sdram_pkg::bank_state_t tgt;
  logic [NB-1:0] idle_vec;
  logic [NB-1:0] pre_ok_vec;
  logic [NB-1:0] write_beat_vec;
  logic [1:0] last_rw_bank_q;
  logic table_ok;
  logic executable;
  logic legal;
  logic accept;
  logic entry_edge;
  sdram_pkg::cmd_t acc;

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      idle_vec[i] = (bank_state[i] == sdram_pkg::BANK_IDLE);
      pre_ok_vec[i] = (bank_state[i] == sdram_pkg::BANK_IDLE) ||
          (bank_state[i] == sdram_pkg::BANK_ACTIVE) ||
          (bank_state[i] == sdram_pkg::BANK_READING) ||
          (bank_state[i] == sdram_pkg::BANK_WRITING);
    end
  end

  assign all_idle = &idle_vec;
  assign tgt = bank_state[dec.bank];
  // gate high on both edges, no exit wait
  assign table_ok = gate_q && gate_prev_q && (dev_state_q == sdram_pkg::DEV_NORMAL);
  assign entry_edge = gate_prev_q && !gate_q && (dev_state_q == sdram_pkg::DEV_NORMAL);
  assign executable = (dec.code != sdram_pkg::CMD_INHIBIT) && (dec.code != sdram_pkg::CMD_NOP);

  // addressed bank state decides ACTIVE, READ, WRITE and one-bank PRECHARGE; the rest check all banks or the last burst bank
  always_comb begin
    legal = 1'b0;
    case (dec.code)
      sdram_pkg::CMD_INHIBIT, sdram_pkg::CMD_NOP: legal = 1'b1;
      sdram_pkg::CMD_ACTIVE: legal = table_ok && (tgt == sdram_pkg::BANK_IDLE);
      sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE:
        legal = table_ok && (tgt == sdram_pkg::BANK_ACTIVE ||
            tgt == sdram_pkg::BANK_READING || tgt == sdram_pkg::BANK_WRITING);
      sdram_pkg::CMD_PRECHARGE:
        legal = table_ok && (dec.auto_precharge ? (&pre_ok_vec) : pre_ok_vec[dec.bank]);
      sdram_pkg::CMD_REFRESH, sdram_pkg::CMD_MODE_LOAD: legal = table_ok && all_idle;
      sdram_pkg::CMD_TERMINATE:
        legal = table_ok && (bank_state[last_rw_bank_q] == sdram_pkg::BANK_READING ||
            bank_state[last_rw_bank_q] == sdram_pkg::BANK_WRITING);
      sdram_pkg::CMD_SELF_REFRESH, sdram_pkg::CMD_DEEP_SLEEP: legal = entry_edge && all_idle;
      default: legal = 1'b0;
    endcase
  end

  // illegal or busy-time commands are flagged and dropped
  assign accept = legal && executable;

  always_comb begin
    acc = dec;
    if (!accept) begin
      acc.code = sdram_pkg::CMD_NOP;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmd_q <= '{code: sdram_pkg::CMD_INHIBIT, bank: 2'h0, auto_precharge: 1'b0};
      cmd_accepted_q <= 1'b0;
      cmd_illegal_q <= 1'b0;
    end else begin
      cmd_q <= dec;
      cmd_accepted_q <= accept;
      cmd_illegal_q <= executable && !legal;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      last_rw_bank_q <= 2'h0;
    end else if (acc.code == sdram_pkg::CMD_READ || acc.code == sdram_pkg::CMD_WRITE) begin
      last_rw_bank_q <= acc.bank;
    end
  end

  // --------------------------------------------------------------------------
  // Device-wide state
  // --------------------------------------------------------------------------
  logic [sdram_pkg::CNT_W-1:0] dev_cnt_q;
  logic dev_done;

  assign dev_done = (dev_cnt_q == sdram_pkg::CNT_ZERO);

  always_ff @(posedge clock) begin
    if (srst) begin
      dev_state_q <= sdram_pkg::DEV_NORMAL;
      dev_cnt_q <= sdram_pkg::CNT_ZERO;
    end else begin
      case (dev_state_q)
        sdram_pkg::DEV_NORMAL: begin
          case (acc.code)
            sdram_pkg::CMD_REFRESH: begin
              dev_state_q <= sdram_pkg::DEV_REFRESHING;
              dev_cnt_q <= sdram_pkg::REFRESH_LOAD;
            end
            sdram_pkg::CMD_MODE_LOAD: begin
              dev_state_q <= sdram_pkg::DEV_MODE_ACCESS;
              dev_cnt_q <= sdram_pkg::MODE_LOAD_LOAD;
            end
            sdram_pkg::CMD_PRECHARGE: begin
              if (acc.auto_precharge) begin
                dev_state_q <= sdram_pkg::DEV_PRECHARGE_ALL;
                dev_cnt_q <= sdram_pkg::PRECHARGE_LOAD;
              end
            end
            sdram_pkg::CMD_SELF_REFRESH: dev_state_q <= sdram_pkg::DEV_SELF_REFRESH;
            sdram_pkg::CMD_DEEP_SLEEP: dev_state_q <= sdram_pkg::DEV_DEEP_SLEEP;
            default: dev_state_q <= sdram_pkg::DEV_NORMAL;
          endcase
        end
        sdram_pkg::DEV_REFRESHING, sdram_pkg::DEV_MODE_ACCESS,
        sdram_pkg::DEV_PRECHARGE_ALL, sdram_pkg::DEV_SR_EXIT: begin
          if (dev_done) begin
            dev_state_q <= sdram_pkg::DEV_NORMAL;
          end else begin
            dev_cnt_q <= dev_cnt_q - 1'b1;
          end
        end
        sdram_pkg::DEV_SELF_REFRESH: begin
          if (gate_q) begin
            dev_state_q <= sdram_pkg::DEV_SR_EXIT;
            dev_cnt_q <= sdram_pkg::SR_EXIT_LOAD;
          end
        end
        sdram_pkg::DEV_DEEP_SLEEP: begin
          if (gate_q) begin
            dev_state_q <= sdram_pkg::DEV_NORMAL;
          end
        end
        default: begin
          dev_state_q <= sdram_pkg::DEV_NORMAL;
          dev_cnt_q <= sdram_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bank trackers
  // --------------------------------------------------------------------------
  logic acc_rw;
  logic acc_read;
  logic acc_term;

  assign acc_read = (acc.code == sdram_pkg::CMD_READ);
  assign acc_rw = acc_read || (acc.code == sdram_pkg::CMD_WRITE);
  assign acc_term = (acc.code == sdram_pkg::CMD_TERMINATE);

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hit;
    logic other;
    logic term;

    assign hit = (acc.bank == 2'(b)) &&
        !(acc.code == sdram_pkg::CMD_PRECHARGE && acc.auto_precharge);
    // burst to another bank ends this one
    assign other = acc_rw && (acc.bank != 2'(b));
    assign term = acc_term && (last_rw_bank_q == 2'(b));

    bank_tracker #(
      .BURST_LEN(BURST_LEN)
    ) u_bank (
      .clock(clock),
      .srst(srst),
      .cmd(acc),
      .hit(hit),
      .other_burst(other),
      .terminate(term),
      .state_q(bank_state[b]),
      .write_beat(write_beat_vec[b])
    );
  end

  // --------------------------------------------------------------------------
  // Data bus ownership
  // --------------------------------------------------------------------------
  logic [READ_LATENCY-1:0] rd_valid_q;
  logic [READ_LATENCY-1:0][1:0] rd_bank_q;
  logic beat_any;
  logic [1:0] beat_bank;

  // new read owns the bus a read latency later
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_valid_q <= '0;
      rd_bank_q <= '0;
    end else begin
      rd_valid_q <= {rd_valid_q[READ_LATENCY-2:0], acc_read};
      rd_bank_q <= {rd_bank_q[READ_LATENCY-2:0], acc.bank};
    end
  end

  assign read_bus_start_q = rd_valid_q[READ_LATENCY-1];
  assign read_bus_bank_q = rd_bank_q[READ_LATENCY-1];

  always_comb begin
    beat_any = 1'b0;
    beat_bank = 2'h0;
    for (int i = 0; i < NB; i++) begin
      if (write_beat_vec[i]) begin
        beat_any = 1'b1;
        beat_bank = 2'(i);
      end
    end
  end

  // word at the interrupting read edge is not taken
  always_ff @(posedge clock) begin
    if (srst) begin
      write_accept_q <= 1'b0;
      write_accept_bank_q <= 2'h0;
    end else if (acc.code == sdram_pkg::CMD_WRITE) begin
      write_accept_q <= 1'b1;
      write_accept_bank_q <= acc.bank;
    end else begin
      write_accept_q <= beat_any && !acc_read && !acc_term &&
          !(acc.code == sdram_pkg::CMD_PRECHARGE);
      write_accept_bank_q <= beat_bank;
    end
  end

endmodule

// ### hw/sdram_pkg.sv
// Shared constants, types and timing counts for the bank command tracker
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package sdram_pkg;

  localparam int CLK_MHZ = 100;
  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 8;
  localparam int BURST_LEN_DEF = 4;
  localparam int READ_LATENCY_DEF = 3;

  // Timing figures in ns
  localparam int PRECHARGE_TIME_NS = 18;
  localparam int REFRESH_CYCLE_TIME_NS = 72;
  localparam int MODE_LOAD_TIME_NS = 20;
  localparam int ACTIVATE_TO_ACCESS_TIME_NS = 18;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 120;

  // Least times round up to whole cycles
  localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MODE_LOAD_CYC = (MODE_LOAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ACTIVATE_CYC = (ACTIVATE_TO_ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS * CLK_MHZ + 999) / 1000;

  // Counter loads: a state lasts load + 1 cycles
  localparam logic [CNT_W-1:0] PRECHARGE_LOAD = CNT_W'(PRECHARGE_CYC - 1);
  localparam logic [CNT_W-1:0] REFRESH_LOAD = CNT_W'(REFRESH_CYC - 1);
  localparam logic [CNT_W-1:0] MODE_LOAD_LOAD = CNT_W'(MODE_LOAD_CYC - 1);
  localparam logic [CNT_W-1:0] ACTIVATE_LOAD = CNT_W'(ACTIVATE_CYC - 1);
  localparam logic [CNT_W-1:0] SR_EXIT_LOAD = CNT_W'(SR_EXIT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // Row, column, write strobe patterns (active low)
  localparam logic [2:0] PAT_NOP = 3'h7;
  localparam logic [2:0] PAT_ACTIVE = 3'h3;
  localparam logic [2:0] PAT_READ = 3'h5;
  localparam logic [2:0] PAT_WRITE = 3'h4;
  localparam logic [2:0] PAT_PRECHARGE = 3'h2;
  localparam logic [2:0] PAT_REFRESH = 3'h1;
  localparam logic [2:0] PAT_MODE_LOAD = 3'h0;
  localparam logic [2:0] PAT_TERMINATE = 3'h6;

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_REFRESH = 4'h6,
    CMD_MODE_LOAD = 4'h7,
    CMD_TERMINATE = 4'h8,
    CMD_DEEP_SLEEP = 4'h9,
    CMD_SELF_REFRESH = 4'ha
  } cmd_code_t;

  typedef enum logic [7:0] {
    BANK_IDLE = 8'h01,
    BANK_ACTIVATING = 8'h02,
    BANK_ACTIVE = 8'h04,
    BANK_READING = 8'h08,
    BANK_WRITING = 8'h10,
    BANK_READ_AP = 8'h20,
    BANK_WRITE_AP = 8'h40,
    BANK_PRECHARGING = 8'h80
  } bank_state_t;

  typedef enum logic [6:0] {
    DEV_NORMAL = 7'h01,
    DEV_REFRESHING = 7'h02,
    DEV_MODE_ACCESS = 7'h04,
    DEV_PRECHARGE_ALL = 7'h08,
    DEV_SELF_REFRESH = 7'h10,
    DEV_SR_EXIT = 7'h20,
    DEV_DEEP_SLEEP = 7'h40
  } dev_state_t;

  // Pins as sampled from the controller
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic [1:0] bank;
    logic auto_precharge;
  } pins_t;

  // Decoded command; auto_precharge doubles as the all-banks flag of PRECHARGE
  typedef struct packed {
    cmd_code_t code;
    logic [1:0] bank;
    logic auto_precharge;
  } cmd_t;

endpackage
